// File: rtl/tmh_defines.vh
// Purpose: Constants for the 8-bit timer unit mode control block.
// Assumes: Byte addresses on a 32-bit Avalon-MM register bus.
// Notes:   Behaviour list follows.
`ifndef TMH_DEFINES_VH
`define TMH_DEFINES_VH

// Register byte addresses.
`define TMH_ADDR_MODE     16'hff6c
`define TMH_ADDR_CMP0     16'hff70
`define TMH_ADDR_CMP1     16'hff74
`define TMH_ADDR_STATUS   16'hff78

// Reset values.
`define TMH_MODE_RESET    8'h00
`define TMH_CMP_RESET     8'hff

// Mode register field positions.
`define TMH_BIT_RUN       7
`define TMH_CKS_HI        6
`define TMH_CKS_LO        4
`define TMH_MD_HI         3
`define TMH_MD_LO         2
`define TMH_BIT_LEVEL     1
`define TMH_BIT_OE        0

// Operation mode codes.
`define TMH_MD_INTERVAL   2'h0
`define TMH_MD_CARRIER    2'h1
`define TMH_MD_PWM        2'h2

// Prescaler division exponents (divide by two to the power).
`define TMH_DIV_PRS_4     2
`define TMH_DIV_PRS_16    4
`define TMH_DIV_PRS_64    6
`define TMH_DIV_PRS_4096  12
`define TMH_DIV_SLOW_64   6
`define TMH_DIV_SLOW_32K  15

`endif

// File: rtl/tmh_mode_ctrl.v
// Purpose: 8-bit timer unit with its mode register, count clock
//          selection and interval, carrier and PWM output generation.
// Assumes: slow_osc_tick is a one-cycle pulse per low-speed oscillator
//          period, synchronous to core_clk; core_clk is the peripheral
//          clock.
// Notes:   Registers are reached over Avalon-MM with waitrequest; each
//          access completes at the second edge.
//          Only byte lane 0 carries register data; upper bits read 0 except status bits 10:8.
//          The prohibited mode code parks the output at its idle level.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tmh_defines.vh"

module tmh_mode_ctrl (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        resetn,
  // Avalon-MM slave.
  input  wire [15:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Low-speed oscillator tick.
  input  wire        slow_osc_tick,
  // Timer output pin.
  output reg         timer_out,
  output reg         timer_out_oe,
  // Compare match event.
  output reg         match_pulse
);

  // Carrier phase states, one-hot.
  localparam ST_LOW  = 2'b01;
  localparam ST_HIGH = 2'b10;

  // Software-visible registers.
  reg  [7:0]  timer_h1_mode_register;
  reg  [7:0]  cmp0_q;
  reg  [7:0]  second_compare_register;

  // Counter and its free-running count-clock dividers.
  reg  [7:0]  count_q;
  reg  [11:0] prs_div_q;
  reg  [14:0] slow_div_q;

  // Bus handshake state.
  reg         ack_q;

  // Output level, carrier phase and restart tracking.
  reg         out_lvl_q;
  reg  [1:0]  phase_q;
  reg         cmp1_fresh_q;
  reg         run_prev_q;

  // Combinational helpers.
  reg         count_tick;
  reg  [7:0]  limit;
  reg  [31:0] rd_d;

  // Mode register fields.
  wire        run_enable;
  wire [2:0]  clock_select;
  wire [1:0]  mode_select;
  wire        output_idle_level;
  wire        output_enable;

  // Bus decode.
  wire        access;
  wire        wr_go;
  wire        rd_go;
  wire        wr_lane0;
  wire        hit;

  assign run_enable        = timer_h1_mode_register[`TMH_BIT_RUN];
  assign clock_select      = timer_h1_mode_register[`TMH_CKS_HI:`TMH_CKS_LO];
  assign mode_select       = timer_h1_mode_register[`TMH_MD_HI:`TMH_MD_LO];
  assign output_idle_level = timer_h1_mode_register[`TMH_BIT_LEVEL];
  assign output_enable     = timer_h1_mode_register[`TMH_BIT_OE];

  // Returns one when the low bits of a free-running divider are all ones.
  // Bits at or above exp_bits are ignored, so one routine serves every
  // divide ratio of both dividers.
  function div_wrap;
    input [14:0] cnt;
    input integer exp_bits;
    integer i;
    reg all_ones;
    begin
      all_ones = 1'b1;
      for (i = 0; i < 15; i = i + 1) begin
        if (i < exp_bits && !cnt[i]) begin
          all_ones = 1'b0;
        end
      end
      div_wrap = all_ones;
    end
  endfunction

  // Each access is held one cycle by waitrequest and completes at the
  // next edge, where ack_q is high.
  assign access          = (avs_read | avs_write) & ~ack_q;
  assign avs_waitrequest = access;
  assign wr_go           = avs_write & ack_q;
  assign rd_go           = avs_read & ~ack_q;
  assign wr_lane0        = wr_go & avs_byteenable[0];
  assign hit             = (avs_address == `TMH_ADDR_MODE);

  // Acknowledge flag toggles the wait off for one cycle per access.
  // A request still held after its done edge starts a fresh two-cycle
  // access, so back-to-back transfers need no idle cycle between them.
  always @(posedge core_clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  // Mode register, the two compares, and the restart reload tracking.
  // Writes land only at the done edge, where ack_q is high, so a request
  // held through its wait cycle is written exactly once.
  always @(posedge core_clk) begin
    if (!resetn) begin
      timer_h1_mode_register  <= `TMH_MODE_RESET;
      cmp0_q                  <= `TMH_CMP_RESET;
      second_compare_register <= `TMH_CMP_RESET;
      cmp1_fresh_q            <= 1'b0;
    end else begin
      if (wr_lane0 && hit) begin
        // While running only the run bit is taken from a write.
        if (run_enable) begin
          timer_h1_mode_register[`TMH_BIT_RUN] <=
            avs_writedata[`TMH_BIT_RUN];
        end else begin
          timer_h1_mode_register <= avs_writedata[7:0];
        end
      end
      if (wr_lane0 && avs_address == `TMH_ADDR_CMP0) begin
        cmp0_q <= avs_writedata[7:0];
      end
      // A cmp1 write marks the value fresh; a stop consumes it.
      if (wr_lane0 && avs_address == `TMH_ADDR_CMP1) begin
        second_compare_register <= avs_writedata[7:0];
        cmp1_fresh_q            <= 1'b1;
      end else if (!run_enable && run_prev_q) begin
        cmp1_fresh_q <= 1'b0;
      end
    end
  end

  // Read data is captured in the wait cycle and stands at the done edge.
  // Unmapped addresses fall through every branch and read as zero.
  always @* begin
    rd_d = 32'h0000_0000;
    if (hit) begin
      rd_d[7:0] = timer_h1_mode_register;
    end else if (avs_address == `TMH_ADDR_CMP0) begin
      rd_d[7:0] = cmp0_q;
    end else if (avs_address == `TMH_ADDR_CMP1) begin
      rd_d[7:0] = second_compare_register;
    end else if (avs_address == `TMH_ADDR_STATUS) begin
      rd_d[7:0]  = count_q;
      rd_d[8]    = timer_out;
      rd_d[9]    = cmp1_fresh_q;
      rd_d[10]   = (mode_select == 2'h3);
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= rd_d;
    end
  end

  // Free-running prescalers for the peripheral and slow clocks.
  // They never restart on a clock-select change or a start, so the first
  // count after a start may come before a full divided period.
  always @(posedge core_clk) begin
    if (!resetn) begin
      prs_div_q  <= 12'h000;
      slow_div_q <= 15'h0000;
    end else begin
      prs_div_q <= prs_div_q + 12'h001;
      if (slow_osc_tick) begin
        slow_div_q <= slow_div_q + 15'h0001;
      end
    end
  end

  // Count clock selection as a one-cycle enable.
  // The slow codes qualify the divider with the tick itself, so each
  // selected count lasts exactly one core_clk cycle.
  always @* begin
    case (clock_select)
      3'h0: count_tick = 1'b1;
      3'h1: count_tick = div_wrap({3'h0, prs_div_q}, `TMH_DIV_PRS_4);
      3'h2: count_tick = div_wrap({3'h0, prs_div_q}, `TMH_DIV_PRS_16);
      3'h3: count_tick = div_wrap({3'h0, prs_div_q}, `TMH_DIV_PRS_64);
      3'h4: count_tick = div_wrap({3'h0, prs_div_q}, `TMH_DIV_PRS_4096);
      3'h5: count_tick = slow_osc_tick &
                         div_wrap(slow_div_q, `TMH_DIV_SLOW_64);
      3'h6: count_tick = slow_osc_tick &
                         div_wrap(slow_div_q, `TMH_DIV_SLOW_32K);
      default: count_tick = slow_osc_tick;
    endcase
  end

  // Active compare: PWM and interval use cmp0 as period; carrier uses
  // cmp1 for the high phase and cmp0 for the low phase.
  // The phase moves on the match tick, so the new limit applies from the
  // first count of the next phase.
  always @* begin
    if (mode_select == `TMH_MD_CARRIER && phase_q == ST_HIGH) begin
      limit = second_compare_register;
    end else begin
      limit = cmp0_q;
    end
  end

  // Counter, phase and output level.
  // A match clears the counter on the same count tick, so one period is
  // the compare value plus one count clocks; match_pulse follows one
  // cycle after the matching tick.
  always @(posedge core_clk) begin
    if (!resetn) begin
      count_q     <= 8'h00;
      out_lvl_q   <= 1'b0;
      phase_q     <= ST_LOW;
      match_pulse <= 1'b0;
      run_prev_q  <= 1'b0;
    end else begin
      run_prev_q  <= run_enable;
      match_pulse <= 1'b0;
      if (!run_enable) begin
        count_q   <= 8'h00;
        out_lvl_q <= output_idle_level;
        phase_q   <= ST_LOW;
      end else if (count_tick) begin
        if (count_q == limit) begin
          count_q     <= 8'h00;
          match_pulse <= 1'b1;
        end else begin
          count_q <= count_q + 8'h01;
        end
        case (mode_select)
          `TMH_MD_INTERVAL: begin
            if (count_q == limit) begin
              out_lvl_q <= ~out_lvl_q;
            end
          end
          `TMH_MD_CARRIER: begin
            if (count_q == limit) begin
              case (phase_q)
                ST_LOW: begin
                  phase_q   <= ST_HIGH;
                  out_lvl_q <= ~output_idle_level;
                end
                default: begin
                  phase_q   <= ST_LOW;
                  out_lvl_q <= output_idle_level;
                end
              endcase
            end
          end
          `TMH_MD_PWM: begin
            // Active from period start until the duty compare matches.
            if (count_q == limit) begin
              out_lvl_q <= ~output_idle_level;
            end else if (count_q == second_compare_register) begin
              out_lvl_q <= output_idle_level;
            end
          end
          default: begin
            // Prohibited code: the output rests at its idle level.
            out_lvl_q <= output_idle_level;
          end
        endcase
      end
      // Prohibited mode code: hold the idle level on every running cycle,
      // not only on count ticks, so a start never shows a stale level.
      if (run_enable && mode_select == 2'h3) begin
        out_lvl_q <= output_idle_level;
      end
    end
  end

  // Output pin: driven only while the output function is enabled.
  // The pin lags the internal level by one cycle; a disabled output is
  // parked low so the pad never shows a stale level.
  always @(posedge core_clk) begin
    if (!resetn) begin
      timer_out    <= 1'b0;
      timer_out_oe <= 1'b0;
    end else begin
      timer_out    <= output_enable ? out_lvl_q : 1'b0;
      timer_out_oe <= output_enable;
    end
  end

endmodule // tmh_mode_ctrl

`default_nettype wire

// File: bench/tmh_mode_ctrl_properties.sv
// Purpose: Port assertions for the timer mode block.
// Assumes: A rule-keeping Avalon-MM master on the bus.
// Notes:   Shadows the mode and period registers.
`timescale 1ns/10ps
`default_nettype none
`include "tmh_defines.vh"
module tmh_mode_ctrl_properties (
  // Clock, reset and bus.
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [15:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Timer side.
  input wire logic        slow_osc_tick,
  input wire logic        timer_out,
  input wire logic        timer_out_oe,
  input wire logic        match_pulse
);
  logic [7:0]  mode_q, per_q, c1_q;
  logic [2:0]  calm_q;
  logic [23:0] gap_q;
  logic        armed_q;
  wire wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire rd = avs_read && !avs_waitrequest;
  wire [2:0] cks = mode_q[6:4];
  wire [23:0] dv = (cks == 3'h4) ? 24'h1000 : 24'h1 << {cks, 1'b0};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Shadow registers, cycles since a write, and cycles between matches.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode_q  <= 8'h00;
      per_q   <= 8'hff;
      c1_q    <= 8'hff;
      calm_q  <= 3'h7;
      armed_q <= 1'b0;
      gap_q   <= 24'h0;
    end else begin
      gap_q   <= match_pulse ? 24'h1 : gap_q + 24'h1;
      calm_q  <= wr ? 3'h0 : calm_q + {2'h0, calm_q != 3'h7};
      armed_q <= !wr && (match_pulse ? mode_q[7] && cks <= 3'h4 : armed_q);
      if (wr && avs_address == `TMH_ADDR_MODE)
        mode_q <= mode_q[7] ? {avs_writedata[7], mode_q[6:0]}
                            : avs_writedata[7:0];
      if (wr && avs_address == `TMH_ADDR_CMP0)
        per_q <= avs_writedata[7:0];
      if (wr && avs_address == `TMH_ADDR_CMP1)
        c1_q <= avs_writedata[7:0];
    end
  end

  oe_follow_a: assert property (timer_out_oe == $past(mode_q[0]))
    else $error("output enable differs from mode bit 0");
  out_off_a: assert property (!timer_out_oe |-> !timer_out)
    else $error("output driven while disabled");
  stop_quiet_a: assert property (!mode_q[7] && calm_q > 3'h2 |->
    !match_pulse) else $error("match while stopped");
  idle_hold_a: assert property (mode_q[3:0] == 4'hd || mode_q[3:0] == 4'hf
    ##0 calm_q > 3'h2 |-> timer_out == mode_q[1])
    else $error("output left idle level in mode 11");
  period_a: assert property (match_pulse && armed_q && mode_q[7] |->
    gap_q == dv * ({16'h0, per_q} + 24'h1) ||
    mode_q[3:2] == `TMH_MD_CARRIER && gap_q == dv * ({16'h0, c1_q} + 24'h1))
    else $error("wrong period");
  reset_quiet_a: assert property (disable iff (1'b0) !resetn |=>
    !timer_out_oe && !timer_out && !match_pulse && avs_readdata == 32'h0)
    else $error("outputs not cleared by reset");
  read_mode_a: assert property (rd && avs_address == `TMH_ADDR_MODE |->
    avs_readdata == {24'h0, mode_q}) else $error("mode read wrong");
  hole_zero_a: assert property (rd && avs_address[15:8] != 8'hff |->
    avs_readdata == 32'h0) else $error("unmapped read not zero");

  cover property (armed_q && match_pulse);
  cover property (wr && mode_q[7] && avs_writedata[6:0] != mode_q[6:0]);
  cover property (rd && avs_address[15:8] != 8'hff);
endmodule // tmh_mode_ctrl_properties
`default_nettype wire

// File: bench/test_tmh_mode_ctrl.sv
// Purpose: Self-checking bench for the timer mode block.
// Assumes: One 25 MHz clock; slow oscillator ticks made here.
// Notes:   An integer model tracks the mode register.
`timescale 1ns/10ps
`default_nettype none
`include "tmh_defines.vh"
module test_tmh_mode_ctrl;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] adr = 16'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        tick = 1'b0;
  logic [31:0] got;
  wire  [31:0] rdata;
  wire         wreq, tout, toe, mp;
  integer      n_errors = 0, checks_done = 0, seed = 40, model = 0;
  integer      tdiv = 3, tcnt = 0, i, n, h;
  integer      dv [8] = '{1, 4, 16, 64, 4096, 64, 32768, 1};
  integer      hi [5] = '{24, 32, 24, 48, 0};
  logic [7:0]  mv [5] = '{8'h03, 8'h07, 8'h0b, 8'h0f, 8'h0d};

  tmh_mode_ctrl u_tmh_mode_ctrl (.core_clk(core_clk), .resetn(resetn),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .slow_osc_tick(tick), .timer_out(tout), .timer_out_oe(toe),
    .match_pulse(mp));

  // Clock and a slow tick every tdiv cycles.
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tcnt <= (tcnt + 1) % tdiv;
    tick <= (tcnt == 0);
  end

  // Compares and counts one value.
  task chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One access; the request stands until waitrequest is sampled low.
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge core_clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    got = rdata;
    if (k == 50)
      n_errors++;
    if (w && a == `TMH_ADDR_MODE)
      model = model[7] ? {d[7], model[6:0]} : d[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge core_clk);
  endtask

  // Cycles between the next two match pulses.
  task gap(output integer c);
    repeat (2) begin
      c = 0;
      do begin
        @(posedge core_clk);
        c++;
      end while (mp !== 1'b1 && c < 70000);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Registers, clock codes, then operation modes.
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    bus(0, `TMH_ADDR_MODE, 0);
    chk(got, 0, "mode after reset");
    chk(toe, 0, "enable after reset");
    for (i = 0; i < 6; i++) begin
      bus(1, `TMH_ADDR_MODE, $random(seed) | (i > 2 ? 32'h80 : 0));
      bus(0, `TMH_ADDR_MODE, 0);
      chk(got, model, "mode readback");
      bus(0, {1'b0, 15'($random(seed))}, 0);
      chk(got, 0, "unmapped read");
    end
    bus(1, `TMH_ADDR_MODE, 0);
    bus(0, `TMH_ADDR_STATUS, 0);
    chk(got[7:0], 0, "count after stop");
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      tdiv = (i == 6) ? 1 : 3;
      bus(1, `TMH_ADDR_CMP0, 0);
      bus(1, `TMH_ADDR_MODE, i << 4);
      bus(1, `TMH_ADDR_CMP1, 0); // Reload before each restart
      bus(1, `TMH_ADDR_MODE, 8'h80 | i << 4);
      gap(n);
      chk(n, dv[i] * (i > 4 ? tdiv : 1), "match period");
      bus(1, `TMH_ADDR_MODE, 0);
    end
    $display("test clock codes done");
    // Fastest count clock, so carrier use keeps the eight-fold margin.
    for (i = 0; i < 5; i++) begin
      bus(1, `TMH_ADDR_MODE, mv[i]);
      bus(1, `TMH_ADDR_CMP0, 3);
      bus(1, `TMH_ADDR_CMP1, 1);
      bus(1, `TMH_ADDR_MODE, mv[i] | 8'h80);
      bus(0, `TMH_ADDR_STATUS, 0);
      chk(got[10:9], {mv[i][3:2] == 2'h3, 1'b1}, "status flags");
      repeat (16) @(posedge core_clk);
      h = 0;
      repeat (48) begin
        @(posedge core_clk);
        h += tout;
      end
      chk(h, hi[i], "high cycles");
      bus(1, `TMH_ADDR_MODE, 0);
    end
    bus(1, `TMH_ADDR_MODE, 8'h0e);
    repeat (3) @(posedge core_clk);
    chk({toe, tout}, 0, "output disabled");
    $display("test modes done");
    wrap_up;
  end

  // Cuts a hang short after the expected run length with margin.
  initial begin
    #(40 * 95000);
    n_errors++;
    wrap_up;
  end
endmodule // test_tmh_mode_ctrl

bind tmh_mode_ctrl tmh_mode_ctrl_properties u_props (.core_clk(core_clk),
  .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .slow_osc_tick(slow_osc_tick),
  .timer_out(timer_out), .timer_out_oe(timer_out_oe),
  .match_pulse(match_pulse));
`default_nettype wire
